// ### include/dds_params.svh
// Field positions, command codes and widths of the serial command decoder.
// Assumes nothing; included by the package, the receiver, the decoder and the bench.
`ifndef DDS_PARAMS_SVH
`define DDS_PARAMS_SVH
`define DDS_W_WORD     16
`define DDS_W_ACC      32
`define DDS_W_PH       12
`define DDS_W_BYTE     8
`define DDS_CNT_LAST   4'hF
`define DDS_CMD_HI     15
`define DDS_CMD_LO     12
`define DDS_ADR_HI     11
`define DDS_ADR_LO     8
`define DDS_DAT_HI     7
`define DDS_B_CTL      15
`define DDS_B_KIND     14
`define DDS_B_SYNC     13
`define DDS_B_SLEEP    13
`define DDS_B_SELECT_SOURCE   12
`define DDS_B_ZERO     12
`define DDS_B_CLR      11
`define DDS_B_FSEL     11
`define DDS_B_PHASE_CHOICE_HIGH    10
`define DDS_B_PHASE_CHOICE_LOW    9
`define DDS_A_BYTE     0
`define DDS_A_HALF     1
`define DDS_A_BANK     2
`define DDS_A_PHASE    3
`define DDS_CMD_PCOMMIT 4'h0
`define DDS_CMD_PDEFER  4'h1
`define DDS_CMD_FCOMMIT 4'h2
`define DDS_CMD_FDEFER  4'h3
`define DDS_CMD_PSEL    4'h4
`define DDS_CMD_FSEL    4'h5
`define DDS_CMD_BOTH    4'h6
`define DDS_CMD_TEST    4'h7
`define DDS_ADDR_MSB    11
`define DDS_ADDR_LSB    20
`endif

// ### include/dds_pkg.sv
// Types shared by the decoder and its serial receiver.
// Assumes dds_params.svh is on the include path.
`default_nettype none
`include "dds_params.svh"
package dds_pkg;
   typedef struct packed {
      logic                    vld;
      logic                    is_freq;
      logic [3:0]              addr;
      logic [`DDS_W_WORD-1:0]  data;
   } dds_commit_s;

   typedef struct packed {
      logic [`DDS_W_ACC-1:0]      freq_a;
      logic [`DDS_W_ACC-1:0]      freq_b;
      logic [3:0][`DDS_W_PH-1:0]  phase;
      logic [`DDS_W_BYTE-1:0]     pdefer;
      logic [`DDS_W_BYTE-1:0]     fdefer;
      logic [2:0]                 sel_bits;
      logic                       sync_en;
      logic                       sel_src;
      logic                       sleep;
      logic                       acc_zero;
      logic                       test_mode;
      logic                       tgl_seen;
      logic [2:0]                 sel_d1;
      logic [2:0]                 sel_d2;
      dds_commit_s                st1;
      dds_commit_s                st2;
      logic [`DDS_W_ACC-1:0]      acc;
      logic [`DDS_W_PH-1:0]       addr;
   } dds_core_s;

   typedef struct packed {
      logic                    rst_meta;
      logic                    rst_sync;
      logic [14:0]             shift;
      logic [3:0]              cnt;
      logic [`DDS_W_WORD-1:0]  word;
      logic                    tgl;
   } dds_rx_s;
endpackage
`default_nettype wire

// ### design/dds_sync3.sv
// Three-stage synchroniser with agreement filter for asynchronous levels.
// Assumes inputs are quasi-static compared with the clock period.
`timescale 1ns/1ps
`default_nettype none
module dds_sync3 #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         resetn_i,
   // Levels
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] level_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } dds_sync_s;
   dds_sync_s q, d;

   always_comb
   begin
      d     = q;
      d.s1  = async_i;
      d.s2  = q.s1;
      d.s3  = q.s2;
      // A change counts only once stages two and three agree
      d.lvl = (~(q.s2 ^ q.s3) & q.s2) | ((q.s2 ^ q.s3) & q.lvl);
      if (!resetn_i)
      begin
         d = '0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      q <= d;
   end

   assign level_o = q.lvl;
endmodule
`default_nettype wire

// ### design/dds_serial_rx.sv
// Serial word receiver on the link clock, falling-edge capture.
// Assumes the host holds frame_sync low for exactly one 16-bit word.
`timescale 1ns/1ps
`default_nettype none
`include "dds_params.svh"
module dds_serial_rx
   import dds_pkg::*;
(
   // Link side
   input  wire logic                   sclk_i,
   input  wire logic                   resetn_i,
   input  wire logic                   frame_sync_i,
   input  wire logic                   serial_input_i,
   // Word handed to the master clock domain
   output logic [`DDS_W_WORD-1:0]      word_o,
   output logic                        word_toggle_o
);
   dds_rx_s q, d;

   always_comb
   begin
      d          = q;
      d.rst_meta = resetn_i;
      d.rst_sync = q.rst_meta;
      if (!q.rst_sync)
      begin
         d.shift = '0;
         d.cnt   = '0;
         d.word  = '0;
         d.tgl   = 1'b0;
      end
      else if (frame_sync_i)
      begin
         d.cnt = '0;
      end
      else
      begin
         d.shift = {q.shift[13:0], serial_input_i};
         d.cnt   = q.cnt + 4'h1;
         if (q.cnt == `DDS_CNT_LAST)
         begin
            // Word stays put until the next frame, so the toggle guards it
            d.word = {q.shift, serial_input_i};
            d.tgl  = ~q.tgl;
            d.cnt  = '0;
         end
      end
   end

   always_ff @(negedge sclk_i)
   begin
      q <= d;
   end

   assign word_o        = q.word;
   assign word_toggle_o = q.tgl;

   a_word_done: assert property (
      @(negedge sclk_i) disable iff (!q.rst_sync)
      !frame_sync_i && q.cnt == `DDS_CNT_LAST |=>
      q.tgl != $past(q.tgl) && q.word[0] == $past(serial_input_i))
      else $error("word not delivered on sixteenth bit");
endmodule
`default_nettype wire

// ### design/dds_cmd_decoder.sv
// Serial command decoder, tuning registers and phase accumulator of a DDS.
// Assumes a host drives the three-wire port; cosine table and DAC are
// outside and consume table_address_o and sleep_o.
//
// Behaviour
// - Word: command D15..D12, address D11..D8, data byte D7..D0.
// - Addresses 0-3 frequency A, 4-7 frequency B, 8-15 phase lo/hi.
// - Frequency bytes sit at bits 7..0, 15..8, 23..16, 31..24.
// - Command 0001 loads the phase defer byte only.
// - Command 0000 writes 12 bits, present plus deferred, to phase.
// - Command 0011 loads the frequency defer byte only.
// - Command 0010 writes 16 bits, present plus deferred, to frequency.
// - Command 0100 loads phase select bits from D9 and D10.
// - Command 0101 loads the frequency select bit from D11.
// - Command 0110 loads all three select bits at once.
// - Control word 10 loads clock alignment from D13, source from D12.
// - Alignment on adds two master clock cycles to loads and selects.
// - Alignment off applies loads and selects without that delay.
// - Source 1 uses stored select bits, source 0 the select pins.
// - Control word 11 loads sleep from D13; sleep freezes the address, and the accumulator unless D12 is set.
// - In that word D12 forces the accumulator to zero phase.
// - D11 clears alignment and source, then needs no further write.
// - Frame sync low frames 16 bits taken on falling serial edges.
// - Phase select value picks offset 0, 1, 2 or 3.
// - Accumulator adds the chosen frequency word every master clock.
// - Chosen phase offset adds to accumulator top bits for the address.
`timescale 1ns/1ps
`default_nettype none
`include "dds_params.svh"
module dds_cmd_decoder
   import dds_pkg::*;
(
   // Master clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  resetn_i,
   // Serial link
   input  wire logic                  sclk_i,
   input  wire logic                  frame_sync_i,
   input  wire logic                  serial_input_i,
   // Select pins
   input  wire logic                  frequency_choice_i,
   input  wire logic                  phase_choice_low_i,
   input  wire logic                  phase_choice_high_i,
   // Core outputs
   output logic [`DDS_W_PH-1:0]       table_address_o,
   output logic                       sleep_o,
   output logic                       sync_enable_o,
   output logic                       select_source_o,
   output logic                       test_mode_o
);
   dds_core_s                q, d;
   logic [`DDS_W_WORD-1:0]   rx_word;
   logic                     rx_tgl;
   logic                     tgl_lvl;
   logic [2:0]               pin_sel;
   logic                     new_word;
   logic [`DDS_W_WORD-1:0]   word;
   logic [3:0]               cmd;
   logic [3:0]               adr;
   logic [`DDS_W_BYTE-1:0]   byt;
   logic [`DDS_W_BYTE-1:0]   dfr;
   dds_commit_s              imm;
   dds_commit_s              apply;
   logic [2:0]               sel_now;
   logic [2:0]               sel_use;
   logic [`DDS_W_ACC-1:0]    freq_use;
   logic [`DDS_W_PH-1:0]     phase_use;

   dds_serial_rx u_rx (
      .sclk_i         (sclk_i),
      .resetn_i       (resetn_i),
      .frame_sync_i   (frame_sync_i),
      .serial_input_i (serial_input_i),
      .word_o         (rx_word),
      .word_toggle_o  (rx_tgl)
   );

   dds_sync3 #(.W(1)) u_sync_tgl (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .async_i  (rx_tgl),
      .level_o  (tgl_lvl)
   );

   dds_sync3 #(.W(3)) u_sync_pins (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .async_i  ({phase_choice_high_i, phase_choice_low_i,
                  frequency_choice_i}),
      .level_o  (pin_sel)
   );

   // Word is read only after its toggle has settled, so it is stable
   assign new_word = tgl_lvl != q.tgl_seen;
   assign word     = rx_word;
   assign cmd      = word[`DDS_CMD_HI:`DDS_CMD_LO];
   assign adr      = word[`DDS_ADR_HI:`DDS_ADR_LO];
   assign byt      = word[`DDS_DAT_HI:0];
   assign dfr      = (cmd == `DDS_CMD_FCOMMIT) ? q.fdefer : q.pdefer;

   always_comb
   begin
      imm         = '0;
      imm.is_freq = cmd == `DDS_CMD_FCOMMIT;
      imm.addr    = adr;
      // Companion byte of the same half comes from the defer register
      imm.data    = adr[`DDS_A_BYTE] ? {byt, dfr} : {dfr, byt};
      if (new_word && !word[`DDS_B_CTL])
      begin
         // Phase commit needs a phase address, frequency one the reverse
         imm.vld = (cmd == `DDS_CMD_PCOMMIT && adr[`DDS_A_PHASE])
                || (cmd == `DDS_CMD_FCOMMIT && !adr[`DDS_A_PHASE]);
      end
   end

   // Aligned loads leave the two-stage pipe, unaligned ones go straight
   assign apply   = q.sync_en ? q.st2 : imm;
   assign sel_now = q.sel_src ? q.sel_bits : pin_sel;
   assign sel_use = q.sync_en ? q.sel_d2 : sel_now;
   assign freq_use  = sel_use[0] ? q.freq_b : q.freq_a;
   assign phase_use = q.phase[sel_use[2:1]];

   always_comb
   begin
      d          = q;
      d.tgl_seen = tgl_lvl;
      d.sel_d1   = sel_now;
      d.sel_d2   = q.sel_d1;
      d.st1      = q.sync_en ? imm : '0;
      d.st2      = q.st1;

      if (apply.vld)
      begin
         if (apply.is_freq)
         begin
            case ({apply.addr[`DDS_A_BANK], apply.addr[`DDS_A_HALF]})
               2'b00:   d.freq_a[15:0]  = apply.data;
               2'b01:   d.freq_a[31:16] = apply.data;
               2'b10:   d.freq_b[15:0]  = apply.data;
               2'b11:   d.freq_b[31:16] = apply.data;
               default: d.freq_a = q.freq_a;
            endcase
         end
         else
         begin
            // Top nibble of the high byte is dropped; host sends zero there
            d.phase[apply.addr[2:1]] = apply.data[11:0];
         end
      end

      if (new_word)
      begin
         if (word[`DDS_B_CTL] && !word[`DDS_B_KIND])
         begin
            d.sync_en = word[`DDS_B_SYNC];
            d.sel_src = word[`DDS_B_SELECT_SOURCE];
         end
         else if (word[`DDS_B_CTL])
         begin
            d.sleep    = word[`DDS_B_SLEEP];
            d.acc_zero = word[`DDS_B_ZERO];
            // The clear is a one-shot: nothing of it is stored
            if (word[`DDS_B_CLR])
            begin
               d.sync_en = 1'b0;
               d.sel_src = 1'b0;
            end
         end
         else
         begin
            case (cmd)
               `DDS_CMD_PDEFER: d.pdefer = byt;
               `DDS_CMD_FDEFER: d.fdefer = byt;
               `DDS_CMD_PSEL:
               begin
                  d.sel_bits[1] = word[`DDS_B_PHASE_CHOICE_LOW];
                  d.sel_bits[2] = word[`DDS_B_PHASE_CHOICE_HIGH];
               end
               `DDS_CMD_FSEL: d.sel_bits[0] = word[`DDS_B_FSEL];
               `DDS_CMD_BOTH:
               begin
                  d.sel_bits = {word[`DDS_B_PHASE_CHOICE_HIGH], word[`DDS_B_PHASE_CHOICE_LOW],
                                word[`DDS_B_FSEL]};
               end
               // Reserved code only raises a flag; nothing else changes
               `DDS_CMD_TEST: d.test_mode = 1'b1;
               default: d.test_mode = q.test_mode;
            endcase
         end
      end

      // Sleep stands for stopped clocks: address freezes, accumulator too unless acc_zero clears it
      if (q.acc_zero)
      begin
         d.acc = '0;
      end
      else if (!q.sleep)
      begin
         d.acc = q.acc + freq_use;
      end
      if (!q.sleep)
      begin
         d.addr = q.acc[`DDS_W_ACC-1:`DDS_ADDR_LSB] + phase_use;
      end

      if (!resetn_i)
      begin
         d = '0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      q <= d;
   end

   assign table_address_o = q.addr;
   assign sleep_o         = q.sleep;
   assign sync_enable_o   = q.sync_en;
   assign select_source_o = q.sel_src;
   assign test_mode_o     = q.test_mode;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   sequence s_aligned_take;
      imm.vld && q.sync_en;
   endsequence

   sequence s_late_apply;
      !apply.vld ##1 q.sync_en ##0 apply.vld;
   endsequence

   sequence s_cleared;
      !q.sync_en && !q.sel_src;
   endsequence

   a_aligned_load: assert property (
      s_aligned_take ##1 q.sync_en |-> s_late_apply)
      else $error("aligned load not two cycles late");

   a_direct_load: assert property (
      imm.vld && !q.sync_en |-> apply.vld && apply.data == imm.data)
      else $error("unaligned load delayed");

   a_freq_low_a: assert property (
      apply.vld && apply.is_freq && apply.addr[2:1] == 2'b00
      |=> q.freq_a[15:0] == $past(apply.data))
      else $error("frequency A low half not written");

   a_freq_high_b: assert property (
      apply.vld && apply.is_freq && apply.addr[2:1] == 2'b11
      |=> q.freq_b[31:16] == $past(apply.data) && $stable(q.freq_a))
      else $error("frequency B high half not written");

   a_phase_commit: assert property (
      apply.vld && !apply.is_freq
      |=> q.phase[$past(apply.addr[2:1])] == $past(apply.data[11:0]))
      else $error("phase offset not written");

   a_byte_pair: assert property (
      imm.vld && imm.addr[0] |-> imm.data == {byt, dfr})
      else $error("byte pairing wrong");

   a_phase_defer: assert property (
      new_word && !word[15] && cmd == `DDS_CMD_PDEFER
      |=> q.pdefer == $past(byt) ##1 $stable(q.phase))
      else $error("phase defer disturbed offsets");

   a_freq_defer: assert property (
      new_word && !word[15] && cmd == `DDS_CMD_FDEFER
      |=> q.fdefer == $past(byt) ##1 ($stable(q.freq_a) && $stable(q.freq_b)))
      else $error("frequency defer disturbed words");

   a_phase_select: assert property (
      new_word && !word[15] && cmd == `DDS_CMD_PSEL |=>
      q.sel_bits[2:1] == $past(word[10:9]) && $stable(q.sel_bits[0]))
      else $error("phase select bits not loaded");

   a_freq_select: assert property (
      new_word && !word[15] && cmd == `DDS_CMD_FSEL |=>
      q.sel_bits[0] == $past(word[11]) && $stable(q.sel_bits[2:1]))
      else $error("frequency select bit not loaded");

   a_both_select: assert property (
      new_word && !word[15] && cmd == `DDS_CMD_BOTH
      |=> q.sel_bits == {$past(word[10:9]), $past(word[11])})
      else $error("select bits not loaded together");

   a_align_word: assert property (
      new_word && word[15:14] == 2'b10 |=>
      q.sync_en == $past(word[13]) && q.sel_src == $past(word[12]))
      else $error("alignment and source not loaded");

   a_clear_ctl: assert property (
      new_word && word[15:14] == 2'b11 && word[11] |=>
      s_cleared ##1 s_cleared)
      else $error("clear did not act once");

   a_sel_route: assert property (
      !q.sync_en |-> sel_use == (q.sel_src ? q.sel_bits : pin_sel))
      else $error("select source routing wrong");

   a_acc_zero: assert property (
      q.acc_zero |=> q.acc == '0)
      else $error("accumulator not held at zero");

   a_acc_step: assert property (
      !q.acc_zero && !q.sleep |=> q.acc == $past(q.acc) + $past(freq_use))
      else $error("accumulator step wrong");

   a_sleep_freeze: assert property (
      q.sleep && !q.acc_zero |=> $stable(q.acc) && $stable(q.addr))
      else $error("sleep did not freeze core");

   a_table_addr: assert property (
      !q.sleep |=> q.addr == $past(q.acc[31:20]) + $past(phase_use))
      else $error("table address wrong");

   a_bad_commit: assert property (
      new_word && ((cmd == `DDS_CMD_PCOMMIT && !word[`DDS_ADR_HI])
      || (cmd == `DDS_CMD_FCOMMIT && word[`DDS_ADR_HI]))
      |=> ($stable(q.freq_a) && $stable(q.freq_b) && $stable(q.phase))[*3])
      else $error("misaddressed commit changed a register");

   a_sel_delay: assert property (
      q.sync_en |-> sel_use == $past(sel_now, 2))
      else $error("aligned selection not two cycles late");

   a_select_pick: assert property (
      !q.sync_en && q.sel_src && q.sel_bits[2:1] == 2'b01
      |-> phase_use == q.phase[1])
      else $error("low phase select alone did not pick offset one");

   a_test_flag: assert property (
      new_word && cmd == `DDS_CMD_TEST |=> q.test_mode)
      else $error("reserved command did not raise test flag");
endmodule
`default_nettype wire

// ### tb/dds_host_model.sv
// Host model: drives the three-wire write-only serial port, D15 first.
// Assumes the bench calls pulse and send_word; clock idles high.
`timescale 1ns/1ps
`default_nettype none
module dds_host_model (
   // Serial port
   output logic sclk_o,
   output logic frame_sync_o,
   output logic serial_input_o
);
   initial
   begin
      sclk_o = 1'b1;
      frame_sync_o = 1'b1;
      serial_input_o = 1'b0;
   end

   // Idle edges with the frame closed; receiver reset needs them
   task automatic pulse(input int n);
      repeat (n)
      begin
         #80 sclk_o = 1'b0;
         #80 sclk_o = 1'b1;
      end
   endtask

   task automatic send_word(input logic [15:0] w);
      #7 frame_sync_o = 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         serial_input_o = w[i];
         #80 sclk_o = 1'b0;
         #80 sclk_o = 1'b1;
      end
      #40 frame_sync_o = 1'b1;
      // Released line must not keep the last bit
      serial_input_o = ~w[0];
      pulse(1);
   endtask
endmodule
`default_nettype wire

// ### tb/dds_cmd_decoder_tb.sv
// Self-checking bench for the serial command decoder.
// Assumes dds_params.svh on the include path and the host model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "dds_params.svh"
module dds_cmd_decoder_tb;
   logic        clk_i;
   logic        resetn_i;
   logic        sclk;
   logic        frame_sync;
   logic        serial_input;
   logic        fpin;
   logic [1:0]  ppin;
   logic [11:0] taddr;
   logic        sleep;
   logic        sync_en;
   logic        src;
   logic        tmode;
   logic [11:0] ofs [4];
   int          failures;
   int          comparisons;

   dds_host_model host (
      .sclk_o         (sclk),
      .frame_sync_o   (frame_sync),
      .serial_input_o (serial_input)
   );

   dds_cmd_decoder uut (
      .clk_i               (clk_i),
      .resetn_i            (resetn_i),
      .sclk_i              (sclk),
      .frame_sync_i        (frame_sync),
      .serial_input_i      (serial_input),
      .frequency_choice_i  (fpin),
      .phase_choice_low_i  (ppin[0]),
      .phase_choice_high_i (ppin[1]),
      .table_address_o     (taddr),
      .sleep_o             (sleep),
      .sync_enable_o       (sync_en),
      .select_source_o     (src),
      .test_mode_o         (tmode)
   );

   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("Counts: %0d comparisons, %0d failures", comparisons,
               failures);
      if (failures == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic done(input string name);
      $display("Test %s finished", name);
   endtask

   // One word, then time for crossing, decode and alignment
   task automatic wr(input logic [3:0] cmd, input logic [3:0] adr,
                     input logic [7:0] dat);
      host.send_word({cmd, adr, dat});
      repeat (16) @(negedge clk_i);
   endtask

   // Accumulator step seen in the top twelve bits over one clock
   task automatic step(input logic [11:0] exp);
      logic [11:0] t0;
      logic [11:0] d;
      @(negedge clk_i);
      t0 = taddr;
      @(negedge clk_i);
      d = taddr - t0;
      check(d, exp);
   endtask

   initial
   begin
      #1_000_000;
      failures++;
      conclude();
   end

   initial
   begin
      failures = 0;
      comparisons = 0;
      resetn_i = 1'b0;
      fpin = 1'b0;
      ppin = 2'b00;
      // Held past five cycles so the receiver sees its sclk edges
      fork
         host.pulse(4);
         repeat (5) @(negedge clk_i);
      join
      @(negedge clk_i);
      resetn_i = 1'b1;
      check({taddr, sleep, sync_en, src, tmode}, 16'h0000);
      host.pulse(4);
      done("reset");

      // Accumulator held at zero so the address shows the offset
      wr(4'hD, 4'h0, 8'h00);
      wr(4'h9, 4'h0, 8'h00);
      check({sync_en, src}, 2'b01);
      for (int n = 0; n < 4; n++)
      begin
         ofs[n] = {4'(n + 5), 8'(8'h31 + 8'h22 * n)};
         wr(`DDS_CMD_PSEL, 4'(n << 1), 8'h00);
         wr(`DDS_CMD_PDEFER, 4'h0, {4'h0, ofs[n][11:8]});
         check(taddr, 16'h0000);
         wr(`DDS_CMD_PCOMMIT, 4'(8 + 2 * n), ofs[n][7:0]);
         check(taddr, ofs[n]);
      end
      wr(`DDS_CMD_PSEL, 4'h0, 8'h00);
      wr(`DDS_CMD_PDEFER, 4'h0, 8'h5A);
      wr(`DDS_CMD_PCOMMIT, 4'h9, 8'h03);
      ofs[0] = 12'h35A;
      check(taddr, ofs[0]);
      wr(`DDS_CMD_BOTH, 4'h6, 8'h00);
      check(taddr, ofs[3]);
      done("phase");

      wr(4'hD, 4'h8, 8'h00);
      check({sync_en, src}, 2'b00);
      wr(4'h9, 4'h0, 8'h00);
      check(src, 1'b1);
      wr(4'hD, 4'h8, 8'h00);
      for (int n = 0; n < 4; n++)
      begin
         ppin = 2'(n);
         repeat (10) @(negedge clk_i);
         check(taddr, ofs[n]);
      end
      wr(4'hA, 4'h0, 8'h00);
      check({sync_en, src}, 2'b10);
      ppin = 2'b10;
      repeat (12) @(negedge clk_i);
      check(taddr, ofs[2]);
      wr(`DDS_CMD_PDEFER, 4'h0, 8'h01);
      wr(`DDS_CMD_PCOMMIT, 4'hC, 8'h44);
      check(taddr, 16'h0144);
      done("pins");

      // Word A steps the top bits by one, word B by sixteen
      wr(`DDS_CMD_FDEFER, 4'h0, 8'h00);
      wr(`DDS_CMD_FCOMMIT, 4'h2, 8'h10);
      wr(`DDS_CMD_FDEFER, 4'h0, 8'h01);
      wr(`DDS_CMD_FCOMMIT, 4'h6, 8'h00);
      wr(4'hD, 4'h8, 8'h00);
      wr(4'hC, 4'h0, 8'h00);
      step(12'h001);
      fpin = 1'b1;
      repeat (10) @(negedge clk_i);
      step(12'h010);
      wr(4'h9, 4'h0, 8'h00);
      step(12'h001);
      wr(`DDS_CMD_FSEL, 4'h8, 8'h00);
      step(12'h010);
      wr(`DDS_CMD_BOTH, 4'h0, 8'h00);
      step(12'h001);
      // Phase commit aimed at a frequency address must be refused
      wr(`DDS_CMD_PCOMMIT, 4'h2, 8'hEE);
      step(12'h001);
      done("frequency");

      wr(4'hE, 4'h0, 8'h00);
      check(sleep, 1'b1);
      step(12'h000);
      wr(4'hD, 4'h0, 8'h00);
      check(sleep, 1'b0);
      check(taddr, ofs[0]);
      check(tmode, 1'b0);
      wr(`DDS_CMD_TEST, 4'h0, 8'h00);
      check(tmode, 1'b1);
      done("control");
      conclude();
   end
endmodule
`default_nettype wire
